// ==== hdl/cmpei_pkg.sv ====
// constants, types and register layout of the comparator edge interrupt block
// assumes a 32-bit avalon-mm slave port and a single 125 mhz system clock
// Operation
// - enable bits: channel a b0, channel b b4
// - result flag: 1 above reference, else 0
// - result flags are read-only to software
// - irq enables at input_enable bits 0, 2, 6
// - edge-mode bits 1, 3, 7: one/both edges
// - rewriting edge mode may raise a request
// - filter select: off, f1, f8, f32 sampling
// - filtered level valid after three matching samples
// - enabled channel requests on result change
// - request shares flag, priority, vector with pin
// - channels identical and fully independent
// - registers at 01f8h, 01fah, 01fch, eight bits
package cmpei_pkg;
   // ****************************************
   // bus and register map
   // ****************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam logic [9:0] IDX_CTRL = 10'h1f8; // comparator_control
   localparam logic [9:0] IDX_IEN = 10'h1fa; // input_enable
   localparam logic [9:0] IDX_FSEL = 10'h1fc; // input_filter_select
   localparam logic [9:0] IDX_STAT = 10'h1fd; // sticky event status, write one to clear
   localparam logic [9:0] IDX_MASK = 10'h1fe; // interrupt mask
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] CTRL_RES_MASK = 8'h88; // result bits, never stored
   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_A_ON = 0;
   localparam int CTRL_A_RES = 3;
   localparam int CTRL_B_ON = 4;
   localparam int CTRL_B_RES = 7;
   localparam int IEN_S0_ON = 0;
   localparam int IEN_S0_BOTH = 1;
   localparam int IEN_A_ON = 2;
   localparam int IEN_A_BOTH = 3;
   localparam int IEN_B_ON = 6;
   localparam int IEN_B_BOTH = 7;
   localparam int FSEL_S0 = 0;
   localparam int FSEL_A = 2;
   localparam int FSEL_B = 6;
   localparam int STAT_A = 0;
   localparam int STAT_B = 1;
   // ****************************************
   // sampling clocks and filter
   // ****************************************
   localparam int PRESC_W = 5;
   localparam logic [2:0] F8_LAST = 3'h7; // one tick in eight cycles
   localparam logic [4:0] F32_LAST = 5'h1f; // one tick in thirty-two cycles
   localparam int MATCH_N = 3;
   typedef enum logic [1:0] {FILT_OFF, FILT_F1, FILT_F8, FILT_F32} cmpei_filt_e;
   // per-channel configuration carried as one bundle
   typedef struct packed {
      logic on;
      logic irq_on;
      logic both;
      logic edge_polarity;
      cmpei_filt_e filt;
   } cmpei_chcfg_s;
   // channel state
   typedef struct packed {
      logic [MATCH_N-1:0] sample;
      logic filt;
      logic prev;
      logic req;
   } cmpei_chan_s;
   // top state
   typedef struct packed {
      logic [REG_W-1:0] ctrl;
      logic [REG_W-1:0] ien;
      logic [REG_W-1:0] fsel;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [PRESC_W-1:0] presc;
      logic ack;
      logic [DATA_W-1:0] rdata;
   } cmpei_top_s;
endpackage

// ==== hdl/cmpei_top.sv ====
// comparator edge interrupt logic: channel filter/edge module and register top
// assumes synchronous comparator outputs and an avalon-mm master on the clock
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns

// ****************************************
// one comparator channel
// ****************************************
module cmpei_chan
   import cmpei_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // comparator and configuration
   input wire logic raw_i,
   input wire cmpei_chcfg_s cfg_i,
   input wire logic tick8_i,
   input wire logic tick32_i,
   input wire logic poke_i,
   // results
   output logic result_o,
   output logic req_o
);
   cmpei_chan_s st_reg;
   cmpei_chan_s st_next;
   logic gated;
   logic tick;
   logic cur;
   logic changed;

   // disabled channel reads low
   assign gated = cfg_i.on & raw_i;
   assign result_o = gated;
   assign req_o = st_reg.req;

   // sampling tick from the selected sampling clock
   always_comb
   begin
      case (cfg_i.filt)
         FILT_F1: tick = 1'b1;
         FILT_F8: tick = tick8_i;
         FILT_F32: tick = tick32_i;
         default: tick = 1'b0;
      endcase
   end

   // level seen by the edge detector
   assign cur = (cfg_i.filt == FILT_OFF) ? gated : st_reg.filt;
   assign changed = cur != st_reg.prev;

   // next state
   always_comb
   begin
      st_next = st_reg;
      st_next.prev = cur;
      if (tick)
      begin
         st_next.sample = {st_reg.sample[MATCH_N-2:0], gated};
         if (&st_next.sample || ~|st_next.sample)
         begin
            st_next.filt = gated;
         end
      end
      // request on the chosen edge, or on an edge-mode rewrite
      st_next.req = cfg_i.irq_on & ((changed & (cfg_i.both | (cur == cfg_i.edge_polarity))) | poke_i);
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence raw_step_s;
      cfg_i.filt == FILT_OFF && cfg_i.irq_on && cfg_i.both && $changed(gated);
   endsequence

   nofilt_edge_a: assert property (raw_step_s |=> req_o)
      else $error("unfiltered change gave no request");
   irq_off_a: assert property (!cfg_i.irq_on |=> !req_o)
      else $error("request while interrupt disabled");
   filt_three_a: assert property (cfg_i.filt == FILT_F1 && $stable(cfg_i.filt)
      && st_reg.filt != gated [*3] |=> st_reg.filt == $past(gated))
      else $error("filter did not follow three matching samples");
   mode_poke_a: assert property (poke_i && cfg_i.irq_on |=> req_o)
      else $error("edge mode rewrite gave no request");
   one_edge_a: assert property (!cfg_i.both && cfg_i.irq_on && changed
      && cur != cfg_i.edge_polarity && !poke_i |=> !req_o)
      else $error("request on the wrong edge");
endmodule

// ****************************************
// register top with avalon-mm slave
// ****************************************
module cmpei_top
   import cmpei_pkg::*;
#(
   parameter int AW = ADDR_W
)
(
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // avalon-mm slave
   input wire logic [AW-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [DATA_W-1:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // analog comparators
   input wire logic CMP_A_I,
   input wire logic CMP_B_I,
   output logic CMP_A_ON_O,
   output logic CMP_B_ON_O,
   // pin interrupt controller, shared flag per index
   input wire logic EDGE_POLARITY_A_I,
   input wire logic EDGE_POLARITY_B_I,
   output logic REQ_A_O,
   output logic REQ_B_O,
   output logic SRC0_IRQ_ON_O,
   output logic SRC0_BOTH_EDGES_O,
   output logic [1:0] SRC0_FILTER_SEL_O,
   // interrupt
   output logic IRQ_O
);
   // refuse at elaboration an address bus too narrow for the register map
   if (AW < ADDR_W)
   begin : g_aw_check
      $error("address width too small for the register map");
   end

   cmpei_top_s st_reg;
   cmpei_top_s st_next;
   cmpei_chcfg_s cfg_a;
   cmpei_chcfg_s cfg_b;
   logic [9:0] idx;
   logic hit_ctrl;
   logic hit_ien;
   logic hit_fsel;
   logic hit_stat;
   logic hit_mask;
   logic req_cyc;
   logic wr_go;
   logic [7:0] wb;
   logic [7:0] ctrl_rd;
   logic poke_a;
   logic poke_b;
   logic res_a;
   logic res_b;
   logic ev_a;
   logic ev_b;

   // ****************************************
   // address decode
   // ****************************************
   assign idx = AVS_ADDRESS_I[11:2];
   assign req_cyc = AVS_ADDRESS_I[1:0] == 2'h0 && AVS_BYTEENABLE_I[0];
   assign hit_ctrl = req_cyc && idx == IDX_CTRL;
   assign hit_ien = req_cyc && idx == IDX_IEN;
   assign hit_fsel = req_cyc && idx == IDX_FSEL;
   assign hit_stat = req_cyc && idx == IDX_STAT;
   assign hit_mask = req_cyc && idx == IDX_MASK;
   assign wb = AVS_WRITEDATA_I[7:0];

   // one wait state, write lands when waitrequest is low
   assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~st_reg.ack;
   assign wr_go = AVS_WRITE_I & st_reg.ack;
   assign AVS_READDATA_O = st_reg.rdata;

   // edge-mode rewrite detection per channel
   assign poke_a = wr_go && hit_ien && wb[IEN_A_BOTH] != st_reg.ien[IEN_A_BOTH];
   assign poke_b = wr_go && hit_ien && wb[IEN_B_BOTH] != st_reg.ien[IEN_B_BOTH];

   // channel configuration bundles
   assign cfg_a.on = st_reg.ctrl[CTRL_A_ON];
   assign cfg_a.irq_on = st_reg.ien[IEN_A_ON];
   assign cfg_a.both = st_reg.ien[IEN_A_BOTH];
   assign cfg_a.edge_polarity = EDGE_POLARITY_A_I;
   assign cfg_a.filt = cmpei_filt_e'(st_reg.fsel[FSEL_A +: 2]);
   assign cfg_b.on = st_reg.ctrl[CTRL_B_ON];
   assign cfg_b.irq_on = st_reg.ien[IEN_B_ON];
   assign cfg_b.both = st_reg.ien[IEN_B_BOTH];
   assign cfg_b.edge_polarity = EDGE_POLARITY_B_I;
   assign cfg_b.filt = cmpei_filt_e'(st_reg.fsel[FSEL_B +: 2]);

   // ****************************************
   // two independent channels
   // ****************************************
   cmpei_chan u_chan_a (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .raw_i(CMP_A_I),
      .cfg_i(cfg_a),
      .tick8_i(st_reg.presc[2:0] == F8_LAST),
      .tick32_i(st_reg.presc == F32_LAST),
      .poke_i(poke_a),
      .result_o(res_a),
      .req_o(ev_a)
   );
   cmpei_chan u_chan_b (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .raw_i(CMP_B_I),
      .cfg_i(cfg_b),
      .tick8_i(st_reg.presc[2:0] == F8_LAST),
      .tick32_i(st_reg.presc == F32_LAST),
      .poke_i(poke_b),
      .result_o(res_b),
      .req_o(ev_b)
   );

   // control byte with live result flags
   always_comb
   begin
      ctrl_rd = st_reg.ctrl & ~CTRL_RES_MASK;
      ctrl_rd[CTRL_A_RES] = res_a;
      ctrl_rd[CTRL_B_RES] = res_b;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      st_next = st_reg;
      st_next.presc = st_reg.presc + 1'b1;
      st_next.ack = (AVS_READ_I | AVS_WRITE_I) & ~st_reg.ack;
      // read data captured in the wait cycle
      if (AVS_READ_I && !st_reg.ack)
      begin
         st_next.rdata = '0;
         if (hit_ctrl)
         begin
            st_next.rdata[7:0] = ctrl_rd;
         end
         else if (hit_ien)
         begin
            st_next.rdata[7:0] = st_reg.ien;
         end
         else if (hit_fsel)
         begin
            st_next.rdata[7:0] = st_reg.fsel;
         end
         else if (hit_stat)
         begin
            st_next.rdata[1:0] = st_reg.stat;
         end
         else if (hit_mask)
         begin
            st_next.rdata[1:0] = st_reg.mask;
         end
      end
      // writes; result bits never stored
      if (wr_go && hit_ctrl)
      begin
         st_next.ctrl = wb & ~CTRL_RES_MASK;
      end
      if (wr_go && hit_ien)
      begin
         st_next.ien = wb;
      end
      if (wr_go && hit_fsel)
      begin
         st_next.fsel = wb;
      end
      if (wr_go && hit_mask)
      begin
         st_next.mask = wb[1:0];
      end
      // sticky status, a new event wins over a clear
      if (wr_go && hit_stat)
      begin
         st_next.stat = st_reg.stat & ~wb[1:0];
      end
      st_next.stat[STAT_A] = st_next.stat[STAT_A] | ev_a;
      st_next.stat[STAT_B] = st_next.stat[STAT_B] | ev_b;
   end

   // state register
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign CMP_A_ON_O = st_reg.ctrl[CTRL_A_ON];
   assign CMP_B_ON_O = st_reg.ctrl[CTRL_B_ON];
   assign REQ_A_O = ev_a;
   assign REQ_B_O = ev_b;
   assign SRC0_IRQ_ON_O = st_reg.ien[IEN_S0_ON];
   assign SRC0_BOTH_EDGES_O = st_reg.ien[IEN_S0_BOTH];
   assign SRC0_FILTER_SEL_O = st_reg.fsel[FSEL_S0 +: 2];
   assign IRQ_O = |(st_reg.stat & st_reg.mask);

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   sequence bus_wait_s;
      (AVS_READ_I || AVS_WRITE_I) && !st_reg.ack;
   endsequence

   bus_wait_one_a: assert property (bus_wait_s |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
      else $error("bus answer not after one wait state");
   result_gate_a: assert property (!st_reg.ctrl[CTRL_A_ON] |-> !ctrl_rd[CTRL_A_RES])
      else $error("disabled channel result not zero");
   result_ro_a: assert property (wr_go && hit_ctrl |=> (st_reg.ctrl & CTRL_RES_MASK) == 8'h00)
      else $error("result bit stored by a write");
   enable_write_a: assert property (wr_go && hit_ctrl |=> CMP_B_ON_O == $past(wb[CTRL_B_ON]))
      else $error("channel enable not taken");
   irq_enable_a: assert property (wr_go && hit_ien |=> cfg_a.irq_on == $past(wb[IEN_A_ON]))
      else $error("interrupt enable not taken");
   status_set_a: assert property (ev_b |=> st_reg.stat[STAT_B])
      else $error("event lost from status");
   irq_level_a: assert property (st_reg.stat[STAT_A] && st_reg.mask[STAT_A] |-> IRQ_O)
      else $error("interrupt line low with unmasked status");
endmodule

// ==== test/cmpei_ana.sv ====
// stand-in for the two analog comparators in front of the block
// assumes the bench sets the wanted levels and the block drives the enables
`timescale 1ns/1ns
module cmpei_ana
(
   // clock
   input wire logic clk_i,
   // enables and wanted levels
   input wire logic on_a_i,
   input wire logic on_b_i,
   input wire logic lvl_a_i,
   input wire logic lvl_b_i,
   // comparator outputs
   output logic cmp_a_o = 1'b0,
   output logic cmp_b_o = 1'b0
);
   // ****************************************
   // comparators with one cycle of settling
   // ****************************************
   // 1 while above reference; a disabled one gives no stable level
   always @(posedge clk_i)
   begin
      cmp_a_o <= on_a_i ? lvl_a_i : ~cmp_a_o;
      cmp_b_o <= on_b_i ? lvl_b_i : ~cmp_b_o;
   end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the comparator edge interrupt block
// assumes cmpei_pkg, cmpei_top and cmpei_ana are compiled first
`timescale 1ns/1ns
module tb;
   import cmpei_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata;
   logic wait_rq;
   logic lvl_a = 1'b0;
   logic lvl_b = 1'b0;
   logic pol_a = 1'b0;
   logic pol_b = 1'b0;
   logic cmp_a, cmp_b, on_a, on_b, req_a, req_b, irq;
   logic s0_on, s0_both;
   logic [1:0] s0_fs;
   logic [31:0] got;
   logic [31:0] r;
   logic [31:0] seed = 32'hfe54639c;
   logic [11:0] adr [5];
   logic [7:0] mdl [5];
   int miscompares = 0;
   int check_count = 0;
   int n_a = 0;
   int n_b = 0;
   int i, m, p;
   // ****************************************
   // design, comparators, clock
   // ****************************************
   cmpei_top i_cmpei_top (.CLK_SYS_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_rq), .CMP_A_I(cmp_a), .CMP_B_I(cmp_b),
      .CMP_A_ON_O(on_a), .CMP_B_ON_O(on_b), .EDGE_POLARITY_A_I(pol_a),
      .EDGE_POLARITY_B_I(pol_b), .REQ_A_O(req_a), .REQ_B_O(req_b), .SRC0_IRQ_ON_O(s0_on),
      .SRC0_BOTH_EDGES_O(s0_both), .SRC0_FILTER_SEL_O(s0_fs), .IRQ_O(irq));
   cmpei_ana i_cmpei_ana (.clk_i(clk), .on_a_i(on_a), .on_b_i(on_b), .lvl_a_i(lvl_a),
      .lvl_b_i(lvl_b), .cmp_a_o(cmp_a), .cmp_b_o(cmp_b));
   always #4 clk = ~clk;
   // request pulse counters
   always @(posedge clk)
   begin
      if (req_a === 1'b1) n_a <= n_a + 1;
      if (req_b === 1'b1) n_b <= n_b + 1;
   end
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
      end
   endtask
   // one avalon-mm transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      int k;
      @(posedge clk);
      addr <= a;
      wdata <= {24'h0, d};
      rd <= ~w;
      wr <= w;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk);
         if (wait_rq === 1'b0) break;
      end
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k == 20)
      begin
         $display("[FAIL] %0t bus timeout", $time);
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic wreg(input int n, input logic [7:0] d);
      bus(1'b1, adr[n], d);
      if (n == 0) mdl[0] = d & 8'h77;
      else if (n == 3) mdl[3] = mdl[3] & ~d;
      else mdl[n] = d;
   endtask
   task automatic rreg(input int n);
      logic [7:0] e;
      e = mdl[n];
      if (n == 0) e = e | {mdl[0][4] & lvl_b, 3'h0, mdl[0][0] & lvl_a, 3'h0};
      bus(1'b0, adr[n], 8'h00);
      chk(got, {24'h0, e}, "register read");
   endtask
   // cycles from the level change to the request pulse
   task automatic lat(input int ch, input int lo, input int hi);
      int k;
      for (k = 1; k <= hi + 2; k++)
      begin
         @(posedge clk);
         if ((ch == 0 ? req_a : req_b) === 1'b1) break;
      end
      chk(32'(k >= lo && k <= hi), 1, "request latency");
      mdl[3] = mdl[3] | 8'(1 << ch);
   endtask
   task automatic none(input int w);
      int s;
      @(posedge clk);
      s = n_a + n_b;
      repeat (w) @(posedge clk);
      chk(32'(n_a + n_b - s), 0, "unexpected request");
   endtask
   initial
   begin
      #800000;
      $display("[FAIL] %0t run timeout", $time);
      miscompares++;
      end_of_test();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      adr = '{{IDX_CTRL, 2'b00}, {IDX_IEN, 2'b00}, {IDX_FSEL, 2'b00}, {IDX_STAT, 2'b00},
         {IDX_MASK, 2'b00}};
      mdl = '{default: 8'h00};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++) rreg(i);
      bus(1'b0, 12'h7e4, 8'h00);
      chk(got, 0, "unmapped read");
      $display("test reset and map done");
      for (i = 0; i < 9; i++)
      begin
         r = rnd();
         wreg(i % 3, r[7:0]);
         rreg(i % 3);
         chk(32'({on_b, on_a}), 32'({mdl[0][4], mdl[0][0]}), "enables");
         chk(32'({s0_fs, s0_both, s0_on}), 32'({mdl[2][1:0], mdl[1][1:0]}), "src0");
      end
      @(posedge clk);
      be <= 4'he;
      bus(1'b1, adr[1], 8'h5a);
      be <= 4'hf;
      rreg(1);
      $display("test register access done");
      wreg(1, 8'h00);
      wreg(2, 8'h00);
      wreg(0, 8'h11);
      lvl_a <= 1'b1;
      repeat (4) @(posedge clk);
      rreg(0);
      wreg(0, 8'h10);
      rreg(0);
      wreg(0, 8'h11);
      repeat (12500) @(posedge clk); // settle before irq setup
      pol_a <= 1'b0; // falling polarity first
      wreg(1, 8'h08);
      wreg(1, 8'h0c);
      wreg(3, 8'h03); // clear flags after setup
      $display("test result flag done");
      for (i = 0; i < 2; i++)
      begin
         @(posedge clk);
         lvl_a <= ~lvl_a;
         lat(0, 3, 3);
      end
      none(20);
      rreg(3);
      wreg(4, 8'h02);
      repeat (2) @(posedge clk);
      chk(32'(irq), 0, "masked irq");
      wreg(4, 8'h01);
      repeat (2) @(posedge clk);
      chk(32'(irq), 1, "irq level");
      wreg(3, 8'h01);
      rreg(3);
      chk(32'(irq), 0, "irq cleared");
      $display("test both edges and irq done");
      p = n_a;
      wreg(1, 8'h04); // mode rewrite gives one request
      pol_a <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(n_a - p), 1, "mode rewrite request");
      lvl_a <= 1'b0;
      none(12);
      lvl_a <= 1'b1;
      lat(0, 3, 3);
      wreg(1, 8'h00);
      lvl_a <= 1'b0;
      none(12);
      $display("test one edge done");
      wreg(1, 8'hc0);
      for (m = 1; m < 4; m++)
      begin
         p = (m == 1) ? 1 : (m == 2) ? 8 : 32;
         wreg(2, 8'(m << 6));
         repeat (8 * p) @(posedge clk);
         wreg(3, 8'h03);
         lvl_b <= ~lvl_b;
         repeat (2 * p) @(posedge clk);
         lvl_b <= ~lvl_b;
         none(6 * p);
         lvl_b <= ~lvl_b;
         lat(1, 2 * p, 4 * p + 4);
      end
      rreg(3);
      $display("test filter done");
      end_of_test();
   end
endmodule
